// ==== design/mse_pkg.sv ====
// constants and types shared by the multislope exposure and column offset block
package mse_pkg;
  // geometry of the pixel path
  localparam int LANES     = 12;
  localparam int PIX_W     = 10;
  localparam int SLOTS     = 54;
  localparam int SLOT_W    = 6;
  localparam int REG_AW    = 8;
  localparam int REG_DW    = 16;
  localparam int FIFO_D    = 16;
  localparam int KIND_W    = 2;
  localparam int FIFO_W    = LANES * PIX_W + KIND_W;
  localparam int NCFG      = 13;
  // reference columns behind the last time slot
  localparam logic [4:0] TAIL_DUMMY = 5'h02;
  localparam logic [4:0] TAIL_GREY  = 5'h06;
  localparam logic [4:0] TAIL_BLACK = 5'h08;
  localparam logic [4:0] TAIL_LEN   = TAIL_DUMMY + TAIL_GREY + TAIL_BLACK;
  localparam logic [SLOT_W-1:0] LAST_SLOT = 6'h35;
  // register offsets
  localparam logic [REG_AW-1:0] OFS_MODE_ONE   = 8'h00;
  localparam logic [REG_AW-1:0] OFS_MODE_THREE = 8'h01;
  localparam logic [REG_AW-1:0] OFS_RESET_LEN  = 8'h02;
  localparam logic [REG_AW-1:0] OFS_INT_TIMER  = 8'h03;
  localparam logic [REG_AW-1:0] OFS_DS_TIMER   = 8'h04;
  localparam logic [REG_AW-1:0] OFS_TS_TIMER   = 8'h05;
  localparam logic [REG_AW-1:0] OFS_BLK_TIMER  = 8'h06;
  localparam logic [REG_AW-1:0] OFS_STATUS     = 8'h07;
  localparam logic [REG_AW-1:0] OFS_LANE_BASE  = 8'h10;
  // field positions
  localparam int MODE1_MASTER = 0;
  localparam int MODE1_CLOCKS = 4;
  localparam int MODE1_DS_EN  = 5;
  localparam int MODE1_TS_EN  = 6;
  localparam int MODE3_REF_EN = 2;
  localparam int LANE_OFS_EN  = 1;
  // reset values
  localparam logic [REG_DW-1:0] RST_MODE_ONE = 16'h0001;
  localparam logic [REG_DW-1:0] RST_ZERO     = 16'h0000;
  // sequencer phases
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_RESET = 2'b01,
    PH_INTEG = 2'b10
  } mse_phase_t;
  // column kind tag travelling with each word
  typedef enum logic [1:0] {
    K_PIXEL = 2'b00,
    K_DUMMY = 2'b01,
    K_GREY  = 2'b10,
    K_BLACK = 2'b11
  } mse_kind_t;
endpackage

// ==== design/mse_fifo.sv ====
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module mse_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         sys_clk_in,   // clock
  input  wire logic         rst_n_in,     // async reset, low
  input  wire logic         en_in,        // clock enable
  input  wire logic         in_valid_in,  // write side valid
  output logic              in_ready_out, // write side ready
  input  wire logic [W-1:0] in_data_in,   // write data
  output logic              out_valid_out,// read side valid
  input  wire logic         out_ready_in, // read side ready
  output logic [W-1:0]      out_data_out  // read data from storage
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } mse_fifo_st_t;
  mse_fifo_st_t r, n;
  logic push, pop;

  // honest flags straight from the fill count
  assign in_ready_out  = (r.cnt != (AW+1)'(D));
  assign out_valid_out = (r.cnt != '0);
  assign out_data_out  = r.mem[r.rp];
  assign push = in_valid_in & in_ready_out & en_in;
  assign pop  = out_valid_out & out_ready_in & en_in;

  // pointer and count update
  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = in_data_in;
      n.wp = (r.wp == AW'(D-1)) ? '0 : r.wp + AW'(1);
    end
    if (pop) begin
      n.rp = (r.rp == AW'(D-1)) ? '0 : r.rp + AW'(1);
    end
    n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '0;
    end else if (en_in) begin
      r <= n;
    end
  end
endmodule // mse_fifo
`default_nettype wire

// ==== design/mse_top.sv ====
// multislope exposure sequencer and column offset correction path
// Functional notes
// - master mode fires slope resets at stored stamps
// - slope stamps only when mode one bits set
// - stamps from timer registers, lines or clocks
// - slave mode ignores the exposure timer registers except the black timer
// - reference line read first in each frame
// - reference line values stored per column
// - enabled lane subtracts stored column offset
// - per lane enable in lane config bit 1
// - reference line only with mode three bit 2
// - last slot followed by dummy grey black columns
// - grey and black get black timer integration
// - full frame passes every slot including reference
// - status outputs high during each integration
`timescale 1ns/1ns
`default_nettype none
module mse_top (
  input  wire logic                      sys_clk_in,   // 100 MHz clock
  input  wire logic                      rst_n_in,     // async reset, low
  input  wire logic                      clk_en_in,    // freezes state when low
  input  wire logic [mse_pkg::REG_AW-1:0] reg_addr_in, // register address
  input  wire logic [mse_pkg::REG_DW-1:0] reg_wdata_in,// register write data
  input  wire logic                      reg_wr_in,    // write strobe
  input  wire logic                      reg_rd_in,    // read strobe
  output logic [mse_pkg::REG_DW-1:0]     reg_rdata_out,// read data, next cycle
  input  wire logic                      frame_start_in,  // master exposure start
  input  wire logic                      line_tick_in,    // one pulse per line
  input  wire logic                      integration_control_pin_in, // slave main
  input  wire logic                      second_slope_control_pin_in,// slave ds
  input  wire logic                      third_slope_control_pin_in, // slave ts
  output logic                           exposure_status_out,  // main integration
  output logic                           second_slope_status_out, // ds interval
  output logic                           third_slope_status_out,  // ts interval
  output logic                           second_slope_reset_out,  // ds reset pulse
  output logic                           third_slope_reset_out,   // ts reset pulse
  output logic                           ref_column_int_out,  // grey/black exposure
  input  wire logic                      readout_start_in,    // readout frame start
  output logic                           col_ref_voltage_out, // reference applied
  input  wire logic                      adc_valid_in,        // converter word valid
  output logic                           adc_ready_out,       // path can take word
  input  wire logic [mse_pkg::SLOT_W-1:0] adc_slot_in,        // time slot index
  input  wire logic                      adc_last_in,         // last word of line
  input  wire logic [mse_pkg::LANES*mse_pkg::PIX_W-1:0] adc_data_in, // all lanes
  output logic                           pix_valid_out,       // output word valid
  input  wire logic                      pix_ready_in,        // output word taken
  output logic [mse_pkg::LANES*mse_pkg::PIX_W-1:0] pix_data_out, // corrected lanes
  output logic [mse_pkg::KIND_W-1:0]     pix_kind_out         // column kind tag
);
  typedef struct packed {
    logic [mse_pkg::REG_DW-1:0] mode1;
    logic [mse_pkg::REG_DW-1:0] mode3;
    logic [mse_pkg::REG_DW-1:0] rst_len;
    logic [mse_pkg::REG_DW-1:0] int_tmr;
    logic [mse_pkg::REG_DW-1:0] ds_tmr;
    logic [mse_pkg::REG_DW-1:0] ts_tmr;
    logic [mse_pkg::REG_DW-1:0] blk_tmr;
    logic [mse_pkg::NCFG-1:0][mse_pkg::REG_DW-1:0] lane_cfg;
    logic [mse_pkg::REG_DW-1:0] rd_data;
    mse_pkg::mse_phase_t        phase;
    logic [15:0]                cnt;
    logic                       exp;
    logic                       ds_on;
    logic                       ts_on;
    logic                       ds_rst;
    logic                       ts_rst;
    logic                       blk_on;
    logic [15:0]                blk_cnt;
    logic [2:0]                 pin_q;
    logic                       ref_on;
    logic                       tail_on;
    logic [4:0]                 tail_cnt;
    logic [mse_pkg::SLOTS-1:0][mse_pkg::LANES-1:0][mse_pkg::PIX_W-1:0] ofs;
  } mse_top_st_t;

  mse_top_st_t r, n;
  logic tick, master, push, fifo_rdy;
  logic [mse_pkg::SLOT_W-1:0] slot_i;
  logic [mse_pkg::LANES*mse_pkg::PIX_W-1:0] corr;
  logic [mse_pkg::KIND_W-1:0] kind;

  // kind of a tail word from its position behind the last slot
  function automatic logic [1:0] tail_kind(input logic [4:0] idx);
    if (idx < mse_pkg::TAIL_DUMMY) begin
      return mse_pkg::K_DUMMY;
    end else if (idx < mse_pkg::TAIL_DUMMY + mse_pkg::TAIL_GREY) begin
      return mse_pkg::K_GREY;
    end else begin
      return mse_pkg::K_BLACK;
    end
  endfunction

  assign master = r.mode1[mse_pkg::MODE1_MASTER];
  assign tick   = r.mode1[mse_pkg::MODE1_CLOCKS] | line_tick_in;
  assign adc_ready_out = fifo_rdy & clk_en_in;
  assign push   = adc_valid_in & adc_ready_out;
  assign slot_i = (adc_slot_in < mse_pkg::SLOT_W'(mse_pkg::SLOTS)) ? adc_slot_in : '0;
  assign kind   = r.tail_on ? tail_kind(r.tail_cnt) : mse_pkg::K_PIXEL;

  // offset subtraction per lane; reference and tail words pass untouched
  always_comb begin
    logic [mse_pkg::PIX_W-1:0] raw;
    logic [mse_pkg::PIX_W-1:0] off;
    raw = '0;
    off = '0;
    corr = adc_data_in;
    for (int l = 0; l < mse_pkg::LANES; l++) begin
      raw = adc_data_in[l*mse_pkg::PIX_W +: mse_pkg::PIX_W];
      off = r.ofs[slot_i][l];
      if (r.lane_cfg[l][mse_pkg::LANE_OFS_EN] && !r.ref_on && !r.tail_on) begin
        // clamp keeps dark pixels at code zero instead of wrapping to full scale
        corr[l*mse_pkg::PIX_W +: mse_pkg::PIX_W] = (raw > off) ? raw - off : '0;
      end
    end
  end

  // register file, exposure sequencer and readout tracking
  always_comb begin
    n = r;
    n.ds_rst = 1'b0;
    n.ts_rst = 1'b0;
    n.rd_data = '0;
    n.pin_q = {third_slope_control_pin_in, second_slope_control_pin_in,
               integration_control_pin_in};
    if (reg_wr_in) begin
      if (reg_addr_in == mse_pkg::OFS_MODE_ONE) begin
        n.mode1 = reg_wdata_in;
      end else if (reg_addr_in == mse_pkg::OFS_MODE_THREE) begin
        n.mode3 = reg_wdata_in;
      end else if (reg_addr_in == mse_pkg::OFS_RESET_LEN) begin
        n.rst_len = reg_wdata_in;
      end else if (reg_addr_in == mse_pkg::OFS_INT_TIMER) begin
        n.int_tmr = reg_wdata_in;
      end else if (reg_addr_in == mse_pkg::OFS_DS_TIMER) begin
        n.ds_tmr = reg_wdata_in;
      end else if (reg_addr_in == mse_pkg::OFS_TS_TIMER) begin
        n.ts_tmr = reg_wdata_in;
      end else if (reg_addr_in == mse_pkg::OFS_BLK_TIMER) begin
        n.blk_tmr = reg_wdata_in;
      end else if (reg_addr_in >= mse_pkg::OFS_LANE_BASE &&
                   reg_addr_in < mse_pkg::OFS_LANE_BASE + 8'(mse_pkg::NCFG)) begin
        n.lane_cfg[4'(reg_addr_in - mse_pkg::OFS_LANE_BASE)] = reg_wdata_in;
      end
    end
    // unmapped reads answer zero
    if (reg_rd_in) begin
      if (reg_addr_in == mse_pkg::OFS_MODE_ONE) begin
        n.rd_data = r.mode1;
      end else if (reg_addr_in == mse_pkg::OFS_MODE_THREE) begin
        n.rd_data = r.mode3;
      end else if (reg_addr_in == mse_pkg::OFS_RESET_LEN) begin
        n.rd_data = r.rst_len;
      end else if (reg_addr_in == mse_pkg::OFS_INT_TIMER) begin
        n.rd_data = r.int_tmr;
      end else if (reg_addr_in == mse_pkg::OFS_DS_TIMER) begin
        n.rd_data = r.ds_tmr;
      end else if (reg_addr_in == mse_pkg::OFS_TS_TIMER) begin
        n.rd_data = r.ts_tmr;
      end else if (reg_addr_in == mse_pkg::OFS_BLK_TIMER) begin
        n.rd_data = r.blk_tmr;
      end else if (reg_addr_in == mse_pkg::OFS_STATUS) begin
        n.rd_data = {7'h00, r.tail_on, r.ref_on, r.blk_on, r.ts_on, r.ds_on,
                     r.exp, 1'b0, r.phase};
      end else if (reg_addr_in >= mse_pkg::OFS_LANE_BASE &&
                   reg_addr_in < mse_pkg::OFS_LANE_BASE + 8'(mse_pkg::NCFG)) begin
        n.rd_data = r.lane_cfg[4'(reg_addr_in - mse_pkg::OFS_LANE_BASE)];
      end
    end
    // minimal integration window for the grey and black columns
    if (r.blk_on && tick) begin
      n.blk_cnt = r.blk_cnt + 16'h0001;
      if (r.blk_cnt + 16'h0001 >= r.blk_tmr) begin
        n.blk_on = 1'b0;
      end
    end
    if (!master) begin
      // slave: pins own the timing, of the timer registers only the black timer is looked at
      n.phase = mse_pkg::PH_IDLE;
      n.cnt = '0;
      n.exp = integration_control_pin_in;
      n.ds_on = second_slope_control_pin_in;
      n.ts_on = third_slope_control_pin_in;
      n.ds_rst = second_slope_control_pin_in & ~r.pin_q[1];
      n.ts_rst = third_slope_control_pin_in & ~r.pin_q[2];
      if (integration_control_pin_in && !r.pin_q[0]) begin
        n.blk_on = 1'b1;
        n.blk_cnt = '0;
      end
    end else begin
      case (r.phase)
        mse_pkg::PH_IDLE: begin
          if (frame_start_in) begin
            n.phase = mse_pkg::PH_RESET;
            n.cnt = '0;
          end
        end
        mse_pkg::PH_RESET: begin
          if (tick) begin
            n.cnt = r.cnt + 16'h0001;
            if (r.cnt + 16'h0001 >= r.rst_len) begin
              n.phase = mse_pkg::PH_INTEG;
              n.cnt = '0;
              n.exp = 1'b1;
              n.blk_on = 1'b1;
              n.blk_cnt = '0;
            end
          end
        end
        mse_pkg::PH_INTEG: begin
          if (tick) begin
            n.cnt = r.cnt + 16'h0001;
            // stamps count from the start of integration
            if (r.mode1[mse_pkg::MODE1_DS_EN] && !r.ds_on && r.cnt == r.ds_tmr) begin
              n.ds_on = 1'b1;
              n.ds_rst = 1'b1;
            end
            if (r.mode1[mse_pkg::MODE1_TS_EN] && !r.ts_on && r.cnt == r.ts_tmr) begin
              n.ts_on = 1'b1;
              n.ts_rst = 1'b1;
            end
            if (r.cnt + 16'h0001 >= r.int_tmr) begin
              n.phase = mse_pkg::PH_IDLE;
              n.exp = 1'b0;
              n.ds_on = 1'b0;
              n.ts_on = 1'b0;
            end
          end
        end
        default: begin
          n.phase = mse_pkg::PH_IDLE;
        end
      endcase
    end
    // readout: reference line first, then image lines with a tail each
    if (readout_start_in) begin
      n.ref_on = r.mode3[mse_pkg::MODE3_REF_EN];
      n.tail_on = 1'b0;
      n.tail_cnt = '0;
    end else if (push) begin
      if (r.ref_on && !r.tail_on) begin
        n.ofs[slot_i] = adc_data_in;
      end
      if (r.tail_on) begin
        n.tail_cnt = (r.tail_cnt == mse_pkg::TAIL_LEN) ? r.tail_cnt : r.tail_cnt + 5'h01;
      end else if (adc_slot_in == mse_pkg::LAST_SLOT) begin
        n.tail_on = 1'b1;
        n.tail_cnt = '0;
      end
      if (adc_last_in) begin
        n.ref_on = 1'b0;
        n.tail_on = 1'b0;
        n.tail_cnt = '0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '0;
      r.mode1 <= mse_pkg::RST_MODE_ONE;
    end else if (clk_en_in) begin
      r <= n;
    end
  end

  assign reg_rdata_out = r.rd_data;
  assign exposure_status_out = r.exp;
  assign second_slope_status_out = r.ds_on;
  assign third_slope_status_out = r.ts_on;
  assign second_slope_reset_out = r.ds_rst;
  assign third_slope_reset_out = r.ts_rst;
  assign ref_column_int_out = r.blk_on;
  assign col_ref_voltage_out = r.ref_on;

  // sixteen words of slack so the sink can stall without losing a line
  mse_fifo #(.W(mse_pkg::FIFO_W), .D(mse_pkg::FIFO_D)) u_fifo (
    .sys_clk_in    (sys_clk_in),
    .rst_n_in      (rst_n_in),
    .en_in         (clk_en_in),
    .in_valid_in   (adc_valid_in),
    .in_ready_out  (fifo_rdy),
    .in_data_in    ({kind, corr}),
    .out_valid_out (pix_valid_out),
    .out_ready_in  (pix_ready_in),
    .out_data_out  ({pix_kind_out, pix_data_out})
  );

  // checks on the sequencer and the pixel path
  property p_ds_gate;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (master && $rose(r.ds_on)) |-> $past(r.mode1[mse_pkg::MODE1_DS_EN]);
  endproperty
  a_ds_gate: assert property (p_ds_gate) else $error("ds slope without enable");
  property p_ts_gate;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (master && $rose(r.ts_on)) |-> $past(r.mode1[mse_pkg::MODE1_TS_EN]);
  endproperty
  a_ts_gate: assert property (p_ts_gate) else $error("ts slope without enable");
  property p_ds_time;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (master && $rose(second_slope_status_out)) |->
        ($past(r.cnt) == $past(r.ds_tmr)) && second_slope_reset_out;
  endproperty
  a_ds_time: assert property (p_ds_time) else $error("ds reset off its stamp");
  property p_slave;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (!master && $past(!master) && $past(clk_en_in)) |->
        exposure_status_out == $past(integration_control_pin_in) &&
        third_slope_status_out == $past(third_slope_control_pin_in);
  endproperty
  a_slave: assert property (p_slave) else $error("slave status not from pins");
  property p_main;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      master |-> (exposure_status_out == (r.phase == mse_pkg::PH_INTEG));
  endproperty
  a_main: assert property (p_main) else $error("main status off integration");
  property p_ref;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      $rose(col_ref_voltage_out) |-> $past(r.mode3[mse_pkg::MODE3_REF_EN] && readout_start_in);
  endproperty
  a_ref: assert property (p_ref) else $error("reference line not enabled");
  property p_store;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (push && r.ref_on && !r.tail_on && !readout_start_in) |=>
        r.ofs[$past(slot_i)] == $past(adc_data_in);
  endproperty
  a_store: assert property (p_store) else $error("reference word not stored");
  property p_sub;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (r.lane_cfg[0][mse_pkg::LANE_OFS_EN] && !r.ref_on && !r.tail_on) |->
        corr[mse_pkg::PIX_W-1:0] == ((adc_data_in[mse_pkg::PIX_W-1:0] > r.ofs[slot_i][0]) ?
          adc_data_in[mse_pkg::PIX_W-1:0] - r.ofs[slot_i][0] : '0);
  endproperty
  a_sub: assert property (p_sub) else $error("lane 0 correction wrong");
  property p_tail;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (kind == mse_pkg::K_BLACK) |-> r.tail_cnt >= mse_pkg::TAIL_DUMMY + mse_pkg::TAIL_GREY;
  endproperty
  a_tail: assert property (p_tail) else $error("black column too early");
endmodule // mse_top
`default_nettype wire

// ==== verif/mse_ctl_model.sv ====
// camera controller model: pixel sink and slave integration pins
`timescale 1ns/1ns
`default_nettype none
module mse_ctl_model (
  input  wire logic sys_clk_in,    // clock
  input  wire logic rst_n_in,      // async reset, low
  input  wire logic hold_in,       // bench asks for a long stall
  output logic      pix_ready_out, // word taken
  output logic      int_pin_out,   // main integration pin
  output logic      ds_pin_out,    // second slope pin
  output logic      ts_pin_out     // third slope pin
);
  logic [1:0] beat_r;
  // slow sink: refuses one cycle in three, so the fifo never drains at full rate
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) beat_r <= 2'h0;
    else beat_r <= (beat_r == 2'h2) ? 2'h0 : beat_r + 2'h1;
  end
  assign pix_ready_out = !hold_in && (beat_r != 2'h2);
  // slave exposure: slope pins nest inside an 8 cycle main pulse
  task automatic slave_expose();
    @(posedge sys_clk_in);
    int_pin_out <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    ds_pin_out <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    ts_pin_out <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    {int_pin_out, ds_pin_out, ts_pin_out} <= 3'h0;
  endtask
  // pins idle low between exposures
  initial {int_pin_out, ds_pin_out, ts_pin_out} = 3'h0;
endmodule // mse_ctl_model
`default_nettype wire

// ==== verif/mse_top_tb_top.sv ====
// self-checking bench for the exposure sequencer and column offset path
`timescale 1ns/1ns
`default_nettype none
module mse_top_tb_top;
  localparam int N = mse_pkg::LANES * mse_pkg::PIX_W;
  logic             sys_clk_in = 1'b0;
  logic             rst_n_in = 1'b0;
  logic [7:0]       addr = 8'h00;
  logic [15:0]      wdata = 16'h0000;
  logic             wr = 1'b0, rd = 1'b0, fstart = 1'b0, tick = 1'b0, rstart = 1'b0;
  logic             avalid = 1'b0, alast = 1'b0, hold = 1'b0;
  logic [5:0]       aslot = 6'h00;
  logic [N-1:0]     adata = '0;
  logic [15:0]      rdata;
  logic             aready, pvalid, pready, ipin, dpin, tpin, refv, rci;
  logic             exp_s, ds_s, ts_s, ds_p, ts_p;
  logic [N-1:0]     pdata;
  logic [1:0]       pkind;
  logic [N+1:0]     expq[$];
  logic [9:0]       ofs[64][12];
  logic [11:0]      en;
  logic [15:0]      rv;
  int               gsum_seen = 0, gsum_want = 0;
  // black level target, only printed beside the grey mean at the end; no check uses it
  localparam logic [9:0] BLK_TARGET = 10'h020;
  int               seed = 32'h4b497ef9;
  int               miscompares = 0, checked = 0, cyc = 0, refused = 0;

  mse_top uut (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .frame_start_in(fstart), .line_tick_in(tick),
    .integration_control_pin_in(ipin), .second_slope_control_pin_in(dpin),
    .third_slope_control_pin_in(tpin), .exposure_status_out(exp_s),
    .second_slope_status_out(ds_s), .third_slope_status_out(ts_s),
    .second_slope_reset_out(ds_p), .third_slope_reset_out(ts_p),
    .ref_column_int_out(rci), .readout_start_in(rstart), .col_ref_voltage_out(refv),
    .adc_valid_in(avalid), .adc_ready_out(aready), .adc_slot_in(aslot),
    .adc_last_in(alast), .adc_data_in(adata), .pix_valid_out(pvalid),
    .pix_ready_in(pready), .pix_data_out(pdata), .pix_kind_out(pkind));
  mse_ctl_model ctl (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .hold_in(hold),
    .pix_ready_out(pready), .int_pin_out(ipin), .ds_pin_out(dpin), .ts_pin_out(tpin));

  // free running clock, 10 ns period
  always #5 sys_clk_in = ~sys_clk_in;
  // line ticks only matter in line units, kept alive to exercise the input
  always @(posedge sys_clk_in) tick <= (($random(seed) & 3) == 0);

  task automatic tally_and_finish();
    $display("counts: %0d checked, %0d miscompares", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [N+1:0] seen, input logic [N+1:0] want);
    checked++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_in);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] want);
    @(posedge sys_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_in);
    rd <= 1'b0;
    #1 check(rdata, want);
  endtask
  task automatic pulse_readout(input logic want);
    @(posedge sys_clk_in);
    rstart <= 1'b1;
    @(posedge sys_clk_in);
    rstart <= 1'b0;
    #1 check(refv, want);
  endtask
  // counts status and pulse cycles over a window long enough for one exposure
  task automatic watch(input logic [7:0] ne, nd, nt, nb, ns, nu);
    logic [7:0] e, d, t, b, s, u;
    e = 0; d = 0; t = 0; b = 0; s = 0; u = 0;
    repeat (40) begin
      @(posedge sys_clk_in);
      #1;
      e += exp_s; d += ds_p; t += ts_p; b += rci; s += ds_s; u += ts_s;
    end
    check(s, ns);
    check(u, nu);
    check(e, ne);
    check(d, nd);
    check(t, nt);
    check(b, nb);
  endtask
  // one line: three slots, the last slot, then the tail columns on data lines
  task automatic send_line(input bit is_ref);
    int n;
    logic [5:0] s;
    logic [1:0] k;
    logic [9:0] raw;
    logic [N-1:0] d, want;
    n = is_ref ? 4 : 20;
    @(posedge sys_clk_in);
    for (int i = 0; i < n; i++) begin
      s = (i < 3) ? 6'(i) : mse_pkg::LAST_SLOT;
      k = (i < 4) ? 2'h0 : (i < 6) ? 2'h1 : (i < 12) ? 2'h2 : 2'h3;
      for (int l = 0; l < 12; l++) begin
        raw = 10'($random(seed));
        if (is_ref) ofs[s][l] = raw;
        if (k == 2'h2) gsum_want += raw;
        d[l*10+:10] = raw;
        if (is_ref || k != 2'h0 || !en[l]) want[l*10+:10] = raw;
        else want[l*10+:10] = (raw > ofs[s][l]) ? raw - ofs[s][l] : 10'h0;
      end
      expq.push_back({k, want});
      aslot <= s;
      adata <= d;
      alast <= (i == n - 1);
      avalid <= 1'b1;
      // ready is judged mid-cycle, where it is settled for the coming edge
      do begin
        @(negedge sys_clk_in);
        refused += (aready !== 1'b1);
      end while (aready !== 1'b1);
      @(posedge sys_clk_in);
    end
    avalid <= 1'b0;
  endtask

  // output watcher: each accepted word is matched against the oldest note
  // looked at mid-cycle: the word and both flags are settled and get popped at the next edge
  always @(negedge sys_clk_in) begin
    if (pvalid === 1'b1 && pready === 1'b1) begin
      if (pkind == 2'h2) for (int l = 0; l < 12; l++) gsum_seen += pdata[l*10+:10];
      if (expq.size() == 0) check(1'b1, 1'b0);
      else check({pkind, pdata}, expq.pop_front());
    end
  end
  // hang guard, well above the few hundred cycles the tests need
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (20) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    rd_reg(mse_pkg::OFS_MODE_ONE, mse_pkg::RST_MODE_ONE);
    rd_reg(mse_pkg::OFS_MODE_THREE, mse_pkg::RST_ZERO);
    rd_reg(8'h20, 16'h0000);
    rv = 16'($random(seed));
    wr_reg(mse_pkg::OFS_DS_TIMER, rv);
    rd_reg(mse_pkg::OFS_DS_TIMER, rv);
    $display("test registers done");
    wr_reg(mse_pkg::OFS_RESET_LEN, 16'h0002);
    wr_reg(mse_pkg::OFS_INT_TIMER, 16'h000a);
    wr_reg(mse_pkg::OFS_DS_TIMER, 16'h0006);
    wr_reg(mse_pkg::OFS_TS_TIMER, 16'h0008);
    wr_reg(mse_pkg::OFS_BLK_TIMER, 16'h0003);
    // clock units, slopes on then off
    for (int m = 0; m < 2; m++) begin
      wr_reg(mse_pkg::OFS_MODE_ONE, m ? 16'h0011 : 16'h0071);
      @(posedge sys_clk_in);
      fstart <= 1'b1;
      @(posedge sys_clk_in);
      fstart <= 1'b0;
      watch(8'd10, m ? 8'd0 : 8'd1, m ? 8'd0 : 8'd1, 8'd3,
            m ? 8'd0 : 8'd3, m ? 8'd0 : 8'd1);
    end
    $display("test master exposure done");
    // slave: timers still set but must not shape the 8 cycle exposure
    // clock units keep the black timer window independent of random line ticks
    wr_reg(mse_pkg::OFS_MODE_ONE, 16'h0010);
    fork
      ctl.slave_expose();
      watch(8'd8, 8'd1, 8'd1, 8'd3, 8'd6, 8'd4);
    join
    $display("test slave exposure done");
    en = 12'($random(seed));
    for (int l = 0; l < 12; l++)
      wr_reg(mse_pkg::OFS_LANE_BASE + 8'(l), {14'h0, en[l], 1'b0});
    pulse_readout(1'b0);
    wr_reg(mse_pkg::OFS_MODE_THREE, 16'h0004);
    pulse_readout(1'b1);
    send_line(1'b1);
    // stall the sink while a full line goes in, so the fifo fills and refuses
    fork
      send_line(1'b0);
      begin
        hold <= 1'b1;
        repeat (40) @(posedge sys_clk_in);
        hold <= 1'b0;
      end
    join
    for (int w = 0; w < 300 && expq.size() > 0; w++) @(posedge sys_clk_in);
    check(expq.size(), 0);
    check(refused > 0, 1'b1);
    check(gsum_seen, gsum_want);
    $display("test offset correction done, grey mean %0d target %0d", gsum_seen / 72, BLK_TARGET);
    tally_and_finish();
  end
endmodule // mse_top_tb_top
`default_nettype wire
